// ---- shared/pioc_pkg.sv ----
// process input conditioning and output routing: shared constants and types
// assumes a 32-bit AHB-Lite master and a 250 MHz core clock
package pioc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_SH_LO  = 8'h04;
  localparam logic [7:0] OFS_SH_HI  = 8'h08;
  localparam logic [7:0] OFS_SC_LO  = 8'h0c;
  localparam logic [7:0] OFS_SC_HI  = 8'h10;
  localparam logic [7:0] OFS_ASSIGN = 8'h14;
  localparam logic [7:0] OFS_PER_HT = 8'h18;
  localparam logic [7:0] OFS_PER_CL = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_PV     = 8'h24;
  localparam logic [7:0] OFS_IRQ_ST = 8'h28;
  localparam logic [7:0] OFS_IRQ_MK = 8'h2c;
  // control register fields
  localparam int CTRL_TEMP_BIT   = 0;
  localparam int CTRL_DIRECT_BIT = 1;
  localparam int CTRL_DP_LSB     = 4;
  // output function codes
  localparam logic [3:0] FN_HEAT  = 4'h0;
  localparam logic [3:0] FN_COOL  = 4'h1;
  localparam logic [3:0] FN_AL1   = 4'h2;
  localparam logic [3:0] FN_AL2   = 4'h3;
  localparam logic [3:0] FN_AL3   = 4'h4;
  localparam logic [3:0] FN_HFLT  = 4'h5;
  localparam logic [3:0] FN_LFLT  = 4'h6;
  localparam logic [3:0] FN_ERRIN = 4'hb;
  localparam logic [3:0] FN_ERRAD = 4'hc;
  localparam logic [3:0] FN_NONE  = 4'hf;
  localparam int NUM_FN = 13;
  // reset values
  localparam logic [15:0] SHIFT_RST = 16'h0000;
  localparam logic [15:0] ASSIGN_RST = {FN_AL3, FN_AL2, FN_AL1, FN_HEAT};
  localparam logic [7:0] PERIOD_RST_S = 8'h14;
  localparam logic [15:0] SCALE_LO_RST = 16'h0000;
  localparam logic [15:0] SCALE_HI_RST = 16'h03e8;
  // timing: period counted in 1/256 slots of a second
  localparam longint CLK_HZ = 250_000_000;
  localparam int SLOTS_PER_S = 256;
  localparam int SLOT_CYC = int'(CLK_HZ / SLOTS_PER_S);
  // irq bits
  localparam int IRQ_REJ  = 0;
  localparam int IRQ_HEAT = 1;
  localparam int IRQ_COOL = 2;
  localparam int IRQ_W    = 3;

  typedef struct packed {
    logic [1:0] dp;
    logic       direct;
    logic       temp;
  } pioc_ctrl_t;

  typedef struct packed {
    logic       sel;
    logic       write;
    logic [7:0] addr;
  } pioc_acc_t;
endpackage

// ---- hw/pioc_top.sv ----
// process input conditioning and output routing with AHB-Lite registers
// assumes raw sensor codes and strap arrive asynchronously; function and
// manipulated-variable inputs come from logic on the core clock
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
module pioc_top #(
  parameter int SLOT_CYC = pioc_pkg::SLOT_CYC
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic [15:0] RAW_I,
  input  wire logic        VARIANT_PP_I,
  input  wire logic [12:0] FUNC_I,
  input  wire logic [7:0]  MV_HEAT_I,
  input  wire logic [7:0]  MV_COOL_I,
  output logic      [15:0] PV_O,
  output logic      [1:0]  PV_DP_O,
  output logic      [1:0]  CTL_O,
  output logic      [1:0]  AUX_O,
  output logic             HEAT_COOL_O,
  output logic             IRQ_O
);
  pioc_pkg::pioc_ctrl_t ctrl_ff;
  pioc_pkg::pioc_acc_t  acc_ff;
  logic [15:0] raw_s1_ff;
  logic [15:0] raw_ff;
  logic [15:0] raw_q_ff;
  logic [15:0] raw_ok_ff;
  logic        pp_s1_ff;
  logic        pp_ff;
  logic [15:0] sh_lo_ff;
  logic [15:0] sh_hi_ff;
  logic [15:0] sc_lo_ff;
  logic [15:0] sc_hi_ff;
  logic [15:0] assign_ff;
  logic [7:0]  per_ff [2];
  logic [15:0] phase_ff [2];
  logic [31:0] slot_cnt_ff;
  logic [15:0] pv_ff;
  logic [1:0]  ctl_ff;
  logic [1:0]  aux_ff;
  logic [pioc_pkg::IRQ_W-1:0] irq_st_ff;
  logic [pioc_pkg::IRQ_W-1:0] irq_mk_ff;
  logic [31:0] rdata_ff;
  logic        slot_tick;
  logic [1:0]  wrap;
  logic [1:0]  pulse;
  logic        cool_used;
  logic        wr;
  logic [15:0] nxt_assign;
  logic        rej;
  logic [12:0] fn_lvl;
  logic [pioc_pkg::IRQ_W-1:0] ev;

  // true when a function code may drive a destination (0,1 control; 2,3 aux)
  function automatic logic legal(input logic [1:0] dest, input logic [3:0] code,
                                 input logic pp);
    logic aux;
    aux = dest[1];
    if (code == pioc_pkg::FN_NONE)
      legal = 1'b1;
    else if (code > pioc_pkg::FN_ERRAD)
      legal = 1'b0;
    else if (pp)
      legal = aux && code != pioc_pkg::FN_HEAT && code != pioc_pkg::FN_COOL
              && code != pioc_pkg::FN_HFLT && code != pioc_pkg::FN_LFLT;
    else if (code == pioc_pkg::FN_HEAT || code == pioc_pkg::FN_COOL)
      legal = !aux;
    else if (code == pioc_pkg::FN_ERRIN || code == pioc_pkg::FN_ERRAD)
      legal = aux;
    else
      legal = 1'b1;
  endfunction

  // a + (b - a) * g / 65536, g being f stretched so that code ffff lands on b exactly
  function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
                                       input logic [15:0] f);
    logic signed [16:0] d;
    logic        [16:0] g;
    logic signed [33:0] p;
    g = {1'b0, f} + {16'h0000, f[15]};
    d = $signed({b[15], b}) - $signed({a[15], a});
    p = 34'(d) * $signed({1'b0, g});
    lerp = a + p[31:16];
  endfunction

  // two-flop sync; raw is treated as quasi-static between sensor updates
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      raw_s1_ff <= 16'h0000;
      raw_ff    <= 16'h0000;
      pp_s1_ff  <= 1'b0;
      pp_ff     <= 1'b0;
    end
    else
    begin
      raw_s1_ff <= RAW_I;
      raw_ff    <= raw_s1_ff;
      pp_s1_ff  <= VARIANT_PP_I;
      pp_ff     <= pp_s1_ff;
    end
  end

  // a code caught mid-change may mix old and new bits; take it once two samples agree
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      raw_q_ff  <= 16'h0000;
      raw_ok_ff <= 16'h0000;
    end
    else
    begin
      raw_q_ff <= raw_ff;
      if (raw_ff == raw_q_ff)
        raw_ok_ff <= raw_ff;
    end
  end

  // zero-wait slave: address phase captured, write done in data phase
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      acc_ff <= '0;
    else if (HREADY_I)
    begin
      acc_ff.sel   <= HSEL_I && HTRANS_I[1];
      acc_ff.write <= HWRITE_I;
      acc_ff.addr  <= HADDR_I[7:0];
    end
  end

  assign wr = acc_ff.sel && acc_ff.write;

  always_comb
  begin
    nxt_assign = assign_ff;
    rej = 1'b0;
    for (int d = 0; d < 4; d++)
    begin
      if (legal(2'(d), HWDATA_I[4*d +: 4], pp_ff))
        nxt_assign[4*d +: 4] = HWDATA_I[4*d +: 4];
      else
        rej = 1'b1;
    end
  end

  always_comb
  begin
    cool_used = 1'b0;
    for (int d = 0; d < 4; d++)
      if (assign_ff[4*d +: 4] == pioc_pkg::FN_COOL && legal(2'(d), pioc_pkg::FN_COOL, pp_ff))
        cool_used = 1'b1;
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      ctrl_ff   <= '{dp: 2'h0, direct: 1'b0, temp: 1'b1};
      sh_lo_ff  <= pioc_pkg::SHIFT_RST;
      sh_hi_ff  <= pioc_pkg::SHIFT_RST;
      sc_lo_ff  <= pioc_pkg::SCALE_LO_RST;
      sc_hi_ff  <= pioc_pkg::SCALE_HI_RST;
      assign_ff <= pioc_pkg::ASSIGN_RST;
      per_ff[0] <= pioc_pkg::PERIOD_RST_S;
      per_ff[1] <= pioc_pkg::PERIOD_RST_S;
    end
    else if (wr)
    begin
      unique case (acc_ff.addr)
        pioc_pkg::OFS_CTRL:
        begin
          ctrl_ff.temp <= HWDATA_I[pioc_pkg::CTRL_TEMP_BIT];
          if (!HWDATA_I[pioc_pkg::CTRL_TEMP_BIT])
            ctrl_ff.dp <= HWDATA_I[pioc_pkg::CTRL_DP_LSB +: 2];
          if (!pp_ff)
            ctrl_ff.direct <= HWDATA_I[pioc_pkg::CTRL_DIRECT_BIT];
        end
        pioc_pkg::OFS_SH_LO: sh_lo_ff <= HWDATA_I[15:0];
        pioc_pkg::OFS_SH_HI: sh_hi_ff <= HWDATA_I[15:0];
        pioc_pkg::OFS_SC_LO: if (!ctrl_ff.temp) sc_lo_ff <= HWDATA_I[15:0];
        pioc_pkg::OFS_SC_HI: if (!ctrl_ff.temp) sc_hi_ff <= HWDATA_I[15:0];
        pioc_pkg::OFS_ASSIGN: assign_ff <= nxt_assign;
        pioc_pkg::OFS_PER_HT: if (!pp_ff) per_ff[0] <= HWDATA_I[7:0];
        pioc_pkg::OFS_PER_CL: if (!pp_ff && cool_used) per_ff[1] <= HWDATA_I[7:0];
        default: ;
      endcase
    end
  end

  // process value: shift for temperature, scaling for analog
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      pv_ff <= 16'h0000;
    else if (ctrl_ff.temp)
      pv_ff <= raw_ok_ff + lerp(sh_lo_ff, sh_hi_ff, raw_ok_ff);
    else
      pv_ff <= lerp(sc_lo_ff, sc_hi_ff, raw_ok_ff);
  end

  assign PV_O    = pv_ff;
  assign PV_DP_O = ctrl_ff.temp ? 2'h0 : ctrl_ff.dp;

  // shared slot prescaler; period counted in 1/256 s slots
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      slot_cnt_ff <= 32'h0000_0000;
    else if (slot_tick)
      slot_cnt_ff <= 32'h0000_0000;
    else
      slot_cnt_ff <= slot_cnt_ff + 32'h0000_0001;
  end

  assign slot_tick = slot_cnt_ff == 32'(SLOT_CYC - 1);

  for (genvar c = 0; c < 2; c++)
  begin : g_pulse
    logic [7:0]  mv;
    logic [7:0]  per;
    logic [7:0]  dem;
    logic [15:0] limit;
    assign mv    = (c == 0) ? MV_HEAT_I : MV_COOL_I;
    assign per   = (per_ff[c] == 8'h00) ? 8'h01 : per_ff[c];
    assign limit = {per, 8'h00};
    assign wrap[c] = slot_tick && phase_ff[c] == limit - 16'h0001;

    always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
    begin
      if (!RESET_N_I)
        phase_ff[c] <= 16'h0000;
      else if (wrap[c] || phase_ff[c] >= limit)
        phase_ff[c] <= 16'h0000;
      else if (slot_tick)
        phase_ff[c] <= phase_ff[c] + 16'h0001;
    end

    // reverse action turns the demand around; kept at 8 bits so the inversion stays in range
    assign dem      = ctrl_ff.direct ? mv : ~mv;
    assign pulse[c] = !pp_ff && phase_ff[c] < per * dem;
  end

  always_comb
  begin
    fn_lvl = FUNC_I;
    fn_lvl[pioc_pkg::FN_HEAT] = pulse[0];
    fn_lvl[pioc_pkg::FN_COOL] = pulse[1] && cool_used;
  end

  // routing; an illegal code left by a strap change drives nothing
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      ctl_ff <= 2'b00;
      aux_ff <= 2'b00;
    end
    else
    begin
      for (int d = 0; d < 4; d++)
      begin
        logic [3:0] code;
        logic       lvl;
        code = assign_ff[4*d +: 4];
        lvl  = legal(2'(d), code, pp_ff) && code < 4'(pioc_pkg::NUM_FN)
               && fn_lvl[code];
        if (d < 2)
          ctl_ff[d] <= lvl;
        else
          aux_ff[d-2] <= lvl;
      end
    end
  end

  assign CTL_O       = ctl_ff;
  assign AUX_O       = aux_ff;
  assign HEAT_COOL_O = cool_used;

  // sticky events; a new event beats a same-cycle clear
  always_comb
  begin
    ev = '0;
    ev[pioc_pkg::IRQ_REJ]  = wr && acc_ff.addr == pioc_pkg::OFS_ASSIGN && rej;
    ev[pioc_pkg::IRQ_HEAT] = wrap[0] && !pp_ff;
    ev[pioc_pkg::IRQ_COOL] = wrap[1] && !pp_ff && cool_used;
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      irq_st_ff <= '0;
    else if (wr && acc_ff.addr == pioc_pkg::OFS_IRQ_ST)
      irq_st_ff <= (irq_st_ff & ~HWDATA_I[pioc_pkg::IRQ_W-1:0]) | ev;
    else
      irq_st_ff <= irq_st_ff | ev;
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      irq_mk_ff <= '0;
    else if (wr && acc_ff.addr == pioc_pkg::OFS_IRQ_MK)
      irq_mk_ff <= HWDATA_I[pioc_pkg::IRQ_W-1:0];
  end

  assign IRQ_O = |(irq_st_ff & irq_mk_ff);

  // read data is prepared in the address phase so it leaves a flop
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      rdata_ff <= 32'h0000_0000;
    else if (HREADY_I && HSEL_I && HTRANS_I[1] && !HWRITE_I)
    begin
      unique case (HADDR_I[7:0])
        pioc_pkg::OFS_CTRL:   rdata_ff <= {26'h0, PV_DP_O, 2'h0, ctrl_ff.direct,
                                           ctrl_ff.temp};
        pioc_pkg::OFS_SH_LO:  rdata_ff <= {16'h0, sh_lo_ff};
        pioc_pkg::OFS_SH_HI:  rdata_ff <= {16'h0, sh_hi_ff};
        pioc_pkg::OFS_SC_LO:  rdata_ff <= ctrl_ff.temp ? 32'h0 : {16'h0, sc_lo_ff};
        pioc_pkg::OFS_SC_HI:  rdata_ff <= ctrl_ff.temp ? 32'h0 : {16'h0, sc_hi_ff};
        pioc_pkg::OFS_ASSIGN: rdata_ff <= {16'h0, assign_ff};
        pioc_pkg::OFS_PER_HT: rdata_ff <= {24'h0, per_ff[0]};
        pioc_pkg::OFS_PER_CL: rdata_ff <= {24'h0, per_ff[1]};
        pioc_pkg::OFS_STATUS: rdata_ff <= {24'h0, pulse, aux_ff, ctl_ff, pp_ff, cool_used};
        pioc_pkg::OFS_PV:     rdata_ff <= {16'h0, pv_ff};
        pioc_pkg::OFS_IRQ_ST: rdata_ff <= {29'h0, irq_st_ff};
        pioc_pkg::OFS_IRQ_MK: rdata_ff <= {29'h0, irq_mk_ff};
        default:              rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign HRDATA_O    = rdata_ff;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
endmodule

// ---- verif/pioc_properties.sv ----
// port-level checker for the process io routing block
// assumes one core clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
module pioc_properties (
  input wire logic        CORE_CLK_I,
  input wire logic        RESET_N_I,
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic        HREADYOUT_O,
  input wire logic        HRESP_O,
  input wire logic        VARIANT_PP_I,
  input wire logic [15:0] PV_O,
  input wire logic [1:0]  CTL_O,
  input wire logic [1:0]  AUX_O,
  input wire logic        HEAT_COOL_O,
  input wire logic        IRQ_O
);
  logic rd_take;
  assign rd_take = HSEL_I & HTRANS_I[1] & HREADY_I & !HWRITE_I;
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sequence s_rd(logic [7:0] a);
    rd_take && HADDR_I[7:0] == a;
  endsequence
  chk_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
    else $error("bus answer not ready or not okay");
  chk_rdata_hold: assert property (!rd_take |=> $stable(HRDATA_O))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (rd_take && HADDR_I[7:0] > 8'h2c |=> HRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  chk_pv_read: assert property (s_rd(pioc_pkg::OFS_PV) |=> HRDATA_O == {16'h0, $past(PV_O)})
    else $error("process value read differs from port");
  chk_status_read: assert property (s_rd(pioc_pkg::OFS_STATUS) |=>
    HRDATA_O[5:2] == {$past(AUX_O), $past(CTL_O)} && HRDATA_O[0] == $past(HEAT_COOL_O))
    else $error("status read differs from ports");
  chk_irq_idle: assert property (s_rd(pioc_pkg::OFS_IRQ_ST) ##1 HRDATA_O[2:0] == 3'h0
    |-> !$past(IRQ_O))
    else $error("interrupt high with clear status");
  chk_pp_ctl_off: assert property (VARIANT_PP_I [*5] |-> CTL_O == 2'h0 && !HEAT_COOL_O)
    else $error("control output active on position variant");
  chk_reset_quiet: assert property ($rose(RESET_N_I) |->
    CTL_O == 2'h0 && AUX_O == 2'h0 && !IRQ_O && PV_O == 16'h0)
    else $error("outputs not idle after reset");
endmodule

// ---- verif/pioc_plant.sv ----
// sensor and output-relay model facing the routing block
// assumes the bench names the wanted sensor code and function levels
`timescale 1ns/10ps
module pioc_plant (
  input  wire logic        clk_i,
  input  wire logic [15:0] raw_i,
  input  wire logic [12:0] fn_i,
  input  wire logic [1:0]  ctl_i,
  output logic      [15:0] raw_o,
  output logic      [12:0] fn_o,
  output int               on_cnt_o
);
  initial
  begin
    raw_o = 16'h0;
    fn_o = 13'h0;
    on_cnt_o = 0;
  end
  // sensor settles one cycle after the request; relay 0 (ctl_i[0]) on-time is totalled
  always @(posedge clk_i)
  begin
    raw_o <= raw_i;
    fn_o <= fn_i;
    on_cnt_o <= on_cnt_o + int'(ctl_i[0]);
  end
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for process input conditioning and output routing
// assumes the plant model stands in for sensor and relays
`timescale 1ns/10ps
module tb_top;
  localparam int SLOT = 4;
  logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, pp = 0, hready, hresp, hc, irq;
  logic [1:0]  htrans = 0, dp, ctl, aux;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [15:0] raw = 0, raw_w, pv;
  logic [12:0] fn = 0, fn_w;
  logic [7:0]  mvh = 0, mvc = 0;
  int          on_cnt, errors = 0, num_checks = 0, seed = 32'ha49e7e43, c0, lo, hi, m;
  always #2 clk = ~clk;
  pioc_plant u_plant (.clk_i(clk), .raw_i(raw), .fn_i(fn), .ctl_i(ctl), .raw_o(raw_w),
    .fn_o(fn_w), .on_cnt_o(on_cnt));
  pioc_top #(.SLOT_CYC(SLOT)) u_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .RAW_I(raw_w), .VARIANT_PP_I(pp), .FUNC_I(fn_w), .MV_HEAT_I(mvh),
    .MV_COOL_I(mvc), .PV_O(pv), .PV_DP_O(dp), .CTL_O(ctl), .AUX_O(aux),
    .HEAT_COOL_O(hc), .IRQ_O(irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  function automatic logic [15:0] f_lin(int b, int r, int l, int h);
    return 16'(b + l + ((h - l) * (r + (r >>> 15)) >>> 16));
  endfunction
  function automatic logic route(int c, logic [12:0] f);
    return (c > 1 && c < 13) ? f[c] : 1'b0;
  endfunction
  task summarize();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    errors++;
    summarize();
  end
  initial
  begin
    raw <= 16'($random(seed));
    mvc <= 8'($random(seed));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(pioc_pkg::OFS_CTRL, 32'h1);
    rc(pioc_pkg::OFS_SH_LO, 32'h0);
    rc(pioc_pkg::OFS_SH_HI, 32'h0);
    rc(pioc_pkg::OFS_SC_HI, 32'h0);
    rc(pioc_pkg::OFS_ASSIGN, 32'h4320);
    rc(pioc_pkg::OFS_PER_HT, 32'h14);
    rc(8'h30, 32'h0);
    // a short heat period keeps the pulse test inside the run budget
    bus(1'b1, pioc_pkg::OFS_PER_HT, 32'h1);
    chk(pv, raw);
    for (int i = 0; i < 14; i++)
    begin
      lo = $random(seed) % 1000;
      hi = $random(seed) % 4000;
      raw <= i == 0 ? 16'h0 : (i == 1 || i == 8) ? 16'hffff : 16'($random(seed));
      if (i == 7)
        bus(1'b1, pioc_pkg::OFS_CTRL, 32'h20);
      bus(1'b1, i < 7 ? pioc_pkg::OFS_SH_LO : pioc_pkg::OFS_SC_LO, 32'(lo));
      bus(1'b1, i < 7 ? pioc_pkg::OFS_SH_HI : pioc_pkg::OFS_SC_HI, 32'(hi));
      repeat (6) @(posedge clk);
      chk(pv, f_lin(i < 7 ? int'(raw) : 0, raw, lo, hi));
      rc(pioc_pkg::OFS_PV, 32'(f_lin(i < 7 ? int'(raw) : 0, raw, lo, hi)));
      chk(dp, i < 7 ? 2'h0 : 2'h2);
    end
    $display("test input conditioning done");
    bus(1'b1, pioc_pkg::OFS_IRQ_MK, 32'h1);
    bus(1'b1, pioc_pkg::OFS_ASSIGN, 32'hfff3);
    c0 = 3;
    for (int c = 2; c < 13; c++)
    begin
      bus(1'b1, pioc_pkg::OFS_ASSIGN, {16'h0, 4'(c), 4'(c), 4'hf, 4'(c)});
      c0 = c < 11 ? c : c0;
      fn <= 13'($random(seed));
      repeat (4) @(posedge clk);
      chk({ctl, aux}, {1'b0, route(c0, fn), route(c, fn), route(c, fn)});
      chk(irq, c > 10);
      bus(1'b1, pioc_pkg::OFS_IRQ_ST, 32'h7);
    end
    bus(1'b1, pioc_pkg::OFS_IRQ_MK, 32'h0);
    bus(1'b1, pioc_pkg::OFS_ASSIGN, 32'hfffb);
    rc(pioc_pkg::OFS_ASSIGN, 32'hfffa);
    chk(irq, 1'b0);
    bus(1'b0, pioc_pkg::OFS_IRQ_ST, 32'h0);
    chk(rd[0], 1'b1);
    $display("test routing done");
    bus(1'b1, pioc_pkg::OFS_PER_CL, 32'h5);
    rc(pioc_pkg::OFS_PER_CL, 32'h14);
    chk(hc, 1'b0);
    bus(1'b1, pioc_pkg::OFS_ASSIGN, 32'hff10);
    @(posedge clk);
    chk(hc, 1'b1);
    bus(1'b1, pioc_pkg::OFS_PER_CL, 32'h5);
    rc(pioc_pkg::OFS_PER_CL, 32'h5);
    m = 64 + ($random(seed) & 127);
    mvh <= 8'(m);
    for (int d = 0; d < 2; d++)
    begin
      bus(1'b1, pioc_pkg::OFS_CTRL, 32'(d) << 1);
      repeat (1100) @(posedge clk);
      lo = on_cnt;
      repeat (256 * SLOT) @(posedge clk);
      chk(on_cnt - lo, (d == 1 ? m : 255 - m) * SLOT);
    end
    $display("test pulse output done");
    pp <= 1'b1;
    fn <= 13'($random(seed));
    repeat (4) @(posedge clk);
    bus(1'b1, pioc_pkg::OFS_CTRL, 32'h0);
    rc(pioc_pkg::OFS_CTRL, 32'h2);
    bus(1'b1, pioc_pkg::OFS_ASSIGN, 32'h43ff);
    repeat (4) @(posedge clk);
    chk({hc, ctl, aux}, {3'h0, fn[4], fn[3]});
    rc(pioc_pkg::OFS_STATUS, {24'h0, 2'b00, fn[4], fn[3], 2'b00, 1'b1, 1'b0});
    bus(1'b1, pioc_pkg::OFS_IRQ_ST, 32'h7);
    rc(pioc_pkg::OFS_IRQ_ST, 32'h0);
    $display("test position variant done");
    summarize();
  end
endmodule
bind pioc_top pioc_properties u_chk (.*);
